// file: pph_pkg.sv
/*
  Package for the printer port handshake block: link selection codes,
  character framing and timing counts.
  Assumes a 100 MHz system clock.
*/
package pph_pkg;
  localparam int unsigned CLK_PERIOD_NS = 10;
  // Least strobe low width and data setup before strobe
  localparam int unsigned STROBE_NS = 1000;
  localparam int unsigned SETUP_NS = 500;
  localparam logic [7:0] STROBE_CYC = 8'((STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] SETUP_CYC = 8'((SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int unsigned DATA_W = 8;
  localparam logic [3:0] LAST_DATA_BIT = 4'h8;
  localparam logic [3:0] STOP_BIT = 4'h9;
  localparam logic [15:0] BAUD_DIV_RST = 16'h0363;
  localparam logic [7:0] CNT_ZERO = 8'h00;
  localparam logic LINK_PAR = 1'b0;
  localparam logic LINK_SER = 1'b1;

  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_PSETUP = 7'h02,
    ST_PWAIT = 7'h04,
    ST_PSTROBE = 7'h08,
    ST_SANNOUNCE = 7'h10,
    ST_SWAIT = 7'h20,
    ST_SSHIFT = 7'h40
  } pph_state_t;
endpackage

// file: pph_top.sv
/*
  Printer port handshake: sends characters over a parallel busy/strobe link
  or a serial RTS/DTR against CTS/DSR link, and receives serial bytes on RXD.
  Assumes all inputs synchronous to ref_clk_i and the source holding the
  character stable while char_valid_i is high and char_ready_o is low.
*/
`timescale 1ns/1ps
module pph_top (
  input wire logic ref_clk_i, // System clock, 100 MHz
  input wire logic resetn_i, // Async reset, active low
  input wire logic link_sel_i, // 0 parallel, 1 serial
  input wire logic [15:0] baud_div_i, // Clocks per serial bit minus one
  input wire logic [7:0] char_data_i, // Character to send
  input wire logic char_valid_i, // Character offered
  output logic char_ready_o, // Character taken, one cycle
  output logic [7:0] pdata_o, // Parallel data lines
  output logic strobe_n_o, // Parallel strobe, active low
  input wire logic busy_i, // Printer busy
  output logic txd_o, // Serial data out
  output logic rts_o, // Ready to send
  output logic dtr_o, // Terminal ready
  input wire logic cts_i, // Printer clear to send
  input wire logic dsr_i, // Printer data set ready
  input wire logic rxd_i, // Serial data in
  output logic [7:0] rx_data_o, // Received byte
  output logic rx_valid_o // Received byte pulse
);

  typedef struct packed {
    pph_pkg::pph_state_t st;
    logic [7:0] cnt;
    logic [15:0] baud_cnt;
    logic [3:0] bit_idx;
    logic [8:0] shreg;
    logic go_ok;
    logic ready;
    logic [7:0] pdata;
    logic strobe_n;
    logic txd;
    logic rts;
    logic dtr;
    logic [15:0] rx_baud;
    logic [3:0] rx_idx;
    logic rx_busy;
    logic [7:0] rx_sh;
    logic [7:0] rx_data;
    logic rx_valid;
  } pph_state_reg_t;

  pph_state_reg_t s_ff;
  pph_state_reg_t nxt_s;

  function automatic logic [15:0] half_div(input logic [15:0] d);
    half_div = {1'b0, d[15:1]};
  endfunction

  always_comb begin
    nxt_s = s_ff;
    nxt_s.ready = 1'b0;
    nxt_s.rx_valid = 1'b0;
    case (s_ff.st)
      pph_pkg::ST_IDLE: begin
        if (char_valid_i) begin
          if (link_sel_i == pph_pkg::LINK_PAR) begin
            nxt_s.pdata = char_data_i;
            nxt_s.cnt = pph_pkg::SETUP_CYC;
            nxt_s.st = pph_pkg::ST_PSETUP;
          end else begin
            nxt_s.rts = 1'b1;
            nxt_s.dtr = 1'b1;
            nxt_s.shreg = {char_data_i, 1'b0};
            nxt_s.st = pph_pkg::ST_SANNOUNCE;
          end
        end
      end
      pph_pkg::ST_PSETUP: begin
        if (s_ff.cnt == pph_pkg::CNT_ZERO) begin
          nxt_s.st = pph_pkg::ST_PWAIT;
        end else begin
          nxt_s.cnt = s_ff.cnt - 8'h01;
        end
      end
      pph_pkg::ST_PWAIT: begin
        if (!busy_i) begin
          nxt_s.strobe_n = 1'b0;
          nxt_s.cnt = pph_pkg::STROBE_CYC;
          nxt_s.st = pph_pkg::ST_PSTROBE;
        end
      end
      pph_pkg::ST_PSTROBE: begin
        // Data held through the strobe so the printer reads a steady byte
        if (s_ff.cnt == pph_pkg::CNT_ZERO) begin
          nxt_s.strobe_n = 1'b1;
          nxt_s.ready = 1'b1;
          nxt_s.st = pph_pkg::ST_IDLE;
        end else begin
          nxt_s.cnt = s_ff.cnt - 8'h01;
        end
      end
      pph_pkg::ST_SANNOUNCE: begin
        nxt_s.go_ok = cts_i && dsr_i;
        nxt_s.st = pph_pkg::ST_SWAIT;
      end
      pph_pkg::ST_SWAIT: begin
        // Start on a ready sample or live CTS and DSR; the sample taken at the end of data bit 6 is replaced in ST_SANNOUNCE
        if (s_ff.go_ok || (cts_i && dsr_i)) begin
          nxt_s.go_ok = 1'b0;
          nxt_s.txd = 1'b0;
          nxt_s.bit_idx = 4'h0;
          nxt_s.baud_cnt = baud_div_i;
          nxt_s.st = pph_pkg::ST_SSHIFT;
        end
      end
      pph_pkg::ST_SSHIFT: begin
        if (s_ff.baud_cnt != 16'h0000) begin
          nxt_s.baud_cnt = s_ff.baud_cnt - 16'h0001;
        end else begin
          nxt_s.baud_cnt = baud_div_i;
          nxt_s.bit_idx = s_ff.bit_idx + 4'h1;
          if (s_ff.bit_idx == pph_pkg::STOP_BIT) begin
            nxt_s.ready = 1'b1;
            nxt_s.st = pph_pkg::ST_IDLE;
          end else if (s_ff.bit_idx == pph_pkg::LAST_DATA_BIT) begin
            nxt_s.txd = 1'b1;
          end else begin
            nxt_s.shreg = {1'b1, s_ff.shreg[8:1]};
            nxt_s.txd = s_ff.shreg[1];
          end
          if (s_ff.bit_idx == pph_pkg::LAST_DATA_BIT - 4'h1) begin
            nxt_s.go_ok = cts_i && dsr_i;
          end
        end
      end
      default: nxt_s.st = pph_pkg::ST_IDLE;
    endcase
    // Receiver: mid-bit sampling, no overrun detection
    if (!s_ff.rx_busy) begin
      if (!rxd_i) begin
        nxt_s.rx_busy = 1'b1;
        nxt_s.rx_idx = 4'h0;
        nxt_s.rx_baud = half_div(baud_div_i);
      end
    end else if (s_ff.rx_baud != 16'h0000) begin
      nxt_s.rx_baud = s_ff.rx_baud - 16'h0001;
    end else begin
      nxt_s.rx_baud = baud_div_i;
      nxt_s.rx_idx = s_ff.rx_idx + 4'h1;
      if (s_ff.rx_idx == 4'h0 && rxd_i) begin
        nxt_s.rx_busy = 1'b0;
      end else if (s_ff.rx_idx == pph_pkg::STOP_BIT) begin
        nxt_s.rx_busy = 1'b0;
        if (rxd_i) begin
          nxt_s.rx_data = s_ff.rx_sh;
          nxt_s.rx_valid = 1'b1;
        end
      end else if (s_ff.rx_idx != 4'h0) begin
        nxt_s.rx_sh = {rxd_i, s_ff.rx_sh[7:1]};
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s_ff <= '{st: pph_pkg::ST_IDLE, cnt: 8'h00, baud_cnt: 16'h0000, bit_idx: 4'h0,
                shreg: 9'h1ff, go_ok: 1'b0, ready: 1'b0, pdata: 8'h00, strobe_n: 1'b1,
                txd: 1'b1, rts: 1'b0, dtr: 1'b0, rx_baud: 16'h0000, rx_idx: 4'h0,
                rx_busy: 1'b0, rx_sh: 8'h00, rx_data: 8'h00, rx_valid: 1'b0};
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign char_ready_o = s_ff.ready;
  assign pdata_o = s_ff.pdata;
  assign strobe_n_o = s_ff.strobe_n;
  assign txd_o = s_ff.txd;
  assign rts_o = s_ff.rts;
  assign dtr_o = s_ff.dtr;
  assign rx_data_o = s_ff.rx_data;
  assign rx_valid_o = s_ff.rx_valid;

  sequence strobe_fall;
    $fell(strobe_n_o);
  endsequence

  a_strobe_not_busy: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    strobe_fall |-> !$past(busy_i)) else $error("Strobe issued while busy");
  a_data_steady_strobe: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    !strobe_n_o |-> $stable(pdata_o)) else $error("Data moved under strobe");
  a_strobe_width: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    strobe_fall |-> !strobe_n_o [*8]) else $error("Strobe too short");
  a_strobe_ends: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    strobe_fall |-> ##[1:120] strobe_n_o) else $error("Strobe stuck low");
  a_ready_with_strobe: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    $rose(strobe_n_o) |-> char_ready_o) else $error("Strobe end without ready");
  a_start_announced: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    $fell(txd_o) && s_ff.bit_idx == 4'h0 |-> rts_o && dtr_o)
    else $error("Start without RTS and DTR");
  a_start_when_ready: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    s_ff.st == pph_pkg::ST_SWAIT && nxt_s.st == pph_pkg::ST_SSHIFT
    |-> s_ff.go_ok || (cts_i && dsr_i)) else $error("Start without printer ready");
  a_start_sampled: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    $fell(txd_o) && s_ff.bit_idx == 4'h0 |-> $past(s_ff.go_ok) || $past(cts_i && dsr_i))
    else $error("Start not backed by a ready sample");
  a_stop_bit_high: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    s_ff.st == pph_pkg::ST_SSHIFT && s_ff.bit_idx == pph_pkg::STOP_BIT |-> txd_o)
    else $error("Stop bit low");
  a_rx_good_stop: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    rx_valid_o |-> $past(rxd_i)) else $error("Byte kept with a low stop bit");
  a_ready_pulse: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    char_ready_o |=> !char_ready_o) else $error("Ready longer than a cycle");
  a_sample_last: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    s_ff.st == pph_pkg::ST_SSHIFT && s_ff.baud_cnt == 16'h0000 && s_ff.bit_idx == 4'h7
    |=> s_ff.go_ok == $past(cts_i && dsr_i)) else $error("Ready not sampled");
endmodule // pph_top

// file: pph_prn_model.sv
/*
  Printer model for the printer port handshake block: busy/strobe capture
  on the parallel link, CTS/DSR levels and a frame receiver on the serial link.
  Assumes the host changes its lines on the rising edge of clk_i.
*/
`timescale 1ns/1ps
module pph_prn_model (
  input wire logic clk_i, // System clock
  input wire logic resetn_i, // Reset, active low
  input wire logic [15:0] baud_div_i, // Clocks per bit minus one
  input wire logic [7:0] busy_len_i, // Busy cycles after each capture
  input wire logic [1:0] block_i, // Bit 0 drops CTS, bit 1 drops DSR
  input wire logic [7:0] pdata_i, // Parallel data from host
  input wire logic strobe_n_i, // Strobe from host
  output logic busy_o, // Busy to host
  input wire logic txd_i, // Serial data from host
  output logic cts_o, // Clear to send
  output logic dsr_o, // Data set ready
  output logic [7:0] cap_o, // Last parallel character
  output logic [31:0] cap_cnt_o, // Parallel characters taken
  output logic [31:0] viol_o, // Strobes seen while busy
  output logic [7:0] ser_o, // Last serial character
  output logic [31:0] ser_cnt_o // Serial characters taken
);
  logic [7:0] busy_cnt;
  logic strobe_q;
  logic [7:0] sh;
  assign busy_o = busy_cnt != 8'h00;
  assign cts_o = !block_i[0];
  assign dsr_o = !block_i[1];
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      busy_cnt <= 8'h00;
      strobe_q <= 1'b1;
      cap_o <= 8'h00;
      cap_cnt_o <= 0;
      viol_o <= 0;
    end else begin
      strobe_q <= strobe_n_i;
      if (busy_cnt != 8'h00) busy_cnt <= busy_cnt - 8'h01;
      // Data taken only at the strobe low edge
      if (strobe_q && !strobe_n_i) begin
        if (busy_o) viol_o <= viol_o + 1;
        cap_o <= pdata_i;
        cap_cnt_o <= cap_cnt_o + 1;
        busy_cnt <= busy_len_i;
      end
    end
  end
  initial begin
    ser_cnt_o = 0;
    ser_o = 8'h00;
    forever begin
      @(posedge clk_i iff (resetn_i && txd_i === 1'b0));
      repeat ((baud_div_i + 1) / 2) @(posedge clk_i);
      for (int i = 0; i < 8; i++) begin
        repeat (baud_div_i + 1) @(posedge clk_i);
        sh[i] = txd_i;
      end
      repeat (baud_div_i + 1) @(posedge clk_i);
      if (txd_i === 1'b1) begin
        ser_o = sh;
        ser_cnt_o++;
      end
    end
  end
endmodule // pph_prn_model

// file: tb.sv
/*
  Self-checking bench for pph_top with the printer model on its far side.
  Assumes a 100 MHz clock and inputs driven at the falling edge.
*/
`timescale 1ns/1ps
module tb;
  logic ref_clk_i = 0, resetn_i = 0, link_sel_i = 0, char_valid_i = 0, busy_i, strobe_n_o;
  logic txd_o, rts_o, dtr_o, cts_i, dsr_i, rxd_i = 1, char_ready_o, rx_valid_o;
  logic [7:0] char_data_i = 8'h00, pdata_o, rx_data_o, busy_len = 8'h00, cap, ser, rx_last;
  logic [15:0] baud_div_i = 16'h0003;
  logic [1:0] blk = 2'h0;
  logic [31:0] cap_n, viol, ser_n;
  int err_total = 0, check_count = 0, cyc = 0, rx_n = 0, bad;
  always #5 ref_clk_i = ~ref_clk_i;
  pph_top u_pph_top (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .link_sel_i(link_sel_i),
    .baud_div_i(baud_div_i), .char_data_i(char_data_i), .char_valid_i(char_valid_i),
    .char_ready_o(char_ready_o), .pdata_o(pdata_o), .strobe_n_o(strobe_n_o), .busy_i(busy_i),
    .txd_o(txd_o), .rts_o(rts_o), .dtr_o(dtr_o), .cts_i(cts_i), .dsr_i(dsr_i), .rxd_i(rxd_i),
    .rx_data_o(rx_data_o), .rx_valid_o(rx_valid_o));
  pph_prn_model u_pph_prn_model (.clk_i(ref_clk_i), .resetn_i(resetn_i), .baud_div_i(baud_div_i),
    .busy_len_i(busy_len), .block_i(blk), .pdata_i(pdata_o), .strobe_n_i(strobe_n_o),
    .busy_o(busy_i), .txd_i(txd_o), .cts_o(cts_i), .dsr_o(dsr_i), .cap_o(cap),
    .cap_cnt_o(cap_n), .viol_o(viol), .ser_o(ser), .ser_cnt_o(ser_n));
  // Line 0 carries character bit 0, so the byte maps straight across
  function automatic logic [7:0] exp_lines(input logic [7:0] c);
    return c;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    $display("Checks %0d, errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic wait_ready();
    do @(negedge ref_clk_i); while (char_ready_o !== 1'b1);
    char_valid_i = 0;
  endtask
  task automatic send(input logic [7:0] c);
    @(negedge ref_clk_i);
    char_data_i = c;
    char_valid_i = 1;
    wait_ready();
  endtask
  task automatic rx_send(input logic [7:0] b, input logic stop);
    logic [9:0] f;
    f = {stop, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rxd_i = f[i];
      repeat (4) @(negedge ref_clk_i);
    end
    rxd_i = 1;
    repeat (12) @(negedge ref_clk_i);
  endtask
  always @(negedge ref_clk_i) if (rx_valid_o === 1'b1) begin
    rx_n++;
    rx_last = rx_data_o;
  end
  always @(posedge ref_clk_i) begin
    cyc++;
    // Ceiling well above the few thousand cycles the run needs
    if (cyc == 60000) begin
      err_total++;
      final_report();
    end
  end
  initial begin
    logic [7:0] c;
    void'($urandom(85252));
    repeat (5) @(negedge ref_clk_i);
    resetn_i = 1;
    chk({strobe_n_o, txd_o, rts_o, dtr_o}, 32'h0000000c);
    for (int k = 0; k < 6; k++) begin
      c = (k == 0) ? 8'h80 : (k == 1) ? 8'h01 : 8'($urandom);
      busy_len = (k == 2) ? 8'hc8 : 8'($urandom_range(0, 200));
      send(c);
      chk(pdata_o, exp_lines(c));
      chk(cap, c);
      chk(cap_n, k + 1);
    end
    chk(viol, 0);
    link_sel_i = 1;
    for (int k = 0; k < 4; k++) begin
      c = 8'($urandom);
      send(c);
      chk({rts_o, dtr_o}, 32'h3);
      chk(ser, c);
    end
    for (int k = 1; k < 3; k++) begin
      fork
        send(8'h5a);
        begin repeat (12) @(negedge ref_clk_i); blk = 2'(k); end
      join
      chk(ser, 8'h5a);
      // Valid was just dropped; let an edge pass before offering again
      @(negedge ref_clk_i);
      c = 8'($urandom);
      char_data_i = c;
      char_valid_i = 1;
      bad = 0;
      repeat (120) @(negedge ref_clk_i) if (txd_o !== 1'b1 || char_ready_o !== 1'b0) bad++;
      chk(bad, 0);
      blk = 2'h0;
      wait_ready();
      chk(ser, c);
    end
    chk(ser_n, 8);
    c = 8'($urandom);
    rx_send(c, 1'b1);
    chk(rx_n, 1);
    chk(rx_last, c);
    rx_send(8'h3c, 1'b0);
    chk(rx_n, 1);
    final_report();
  end
endmodule // tb
